// file: logic/rss_pkg.sv
// Constants and types shared by the regulator start-up sequencer
package rss_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int RSS_CLK_NS = 20;
   localparam int RSS_START_DELAY_US = 100;
   localparam int RSS_START_DELAY_CYC = (RSS_START_DELAY_US * 1000 + RSS_CLK_NS - 1) / RSS_CLK_NS;
   localparam int RSS_SLEW_UV_PER_US = 3250;
   localparam int RSS_REF_LSB_UV = 6250;
   localparam int RSS_STEP_NS = RSS_REF_LSB_UV * 1000 / RSS_SLEW_UV_PER_US;
   localparam int RSS_STEP_CYC = RSS_STEP_NS / RSS_CLK_NS;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int RSS_REF_W = 8;
   localparam int RSS_DLY_W = 13;
   localparam int RSS_STEP_W = 7;
   localparam int RSS_PVID_W = 6;
   localparam int RSS_NOUT = 2;
   localparam int RSS_CORE = 0;
   localparam int RSS_NB = 1;

   // ----------------------------------------------------------------
   // Reference codes, one LSB is 6.25 mV
   // ----------------------------------------------------------------
   localparam logic [7:0] RSS_REF_ZERO = 8'h00;
   localparam logic [7:0] RSS_PVID_TOP_CODE = 8'hF8;
   localparam logic [1:0] RSS_PVID_PAD = 2'h0;
   localparam logic [7:0] RSS_BOOT_CORE [0:3] = '{8'h88, 8'h80, 8'h78, 8'h70};
   localparam logic [7:0] RSS_BOOT_NB [0:3] = '{8'h80, 8'h78, 8'h70, 8'h68};
   localparam logic [7:0] RSS_FIXED_CORE = 8'hA0;
   localparam logic [7:0] RSS_FIXED_NB = 8'hA0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PH_FOUR, PH_THREE, PH_TWO} rss_phase_e;

   typedef enum logic [2:0] {ST_OFF, ST_INIT, ST_DELAY, ST_RAMP, ST_DONE} rss_state_e;

   typedef struct packed {
      logic mainBias;
      logic coreDriverBias;
      logic auxDriverBias;
      logic enable;
      logic modeSelectPin;
      logic phaseThreeSenseNeg;
      logic phaseFourSenseNeg;
      logic fixedVoltageSelect;
      logic serialVidData;
      logic serialVidClock;
      logic coreFbHigh;
      logic nbFbHigh;
      logic inLimits;
      logic [5:0] parallelVid;
   } rss_pins_s;

endpackage : rss_pkg

// file: logic/rss_regulator_startup_sequencer.sv
// Start-up sequencer: power-on qualify, mode latch, phase detect, soft-start
`timescale 1ns/1ps
module rss_regulator_startup_sequencer
   import rss_pkg::*;
#(
   parameter int START_DELAY_CYC = RSS_START_DELAY_CYC
)
(
   input wire logic clk,                          // 50 MHz clock
   input wire logic rst_n,                        // Synchronous reset, active low
   input wire logic mainBiasPorOk,                // Main bias above rising POR
   input wire logic coreDriverBias,               // Core driver bias POR passed
   input wire logic auxDriverBias,                // Northbridge driver bias POR passed
   input wire logic enableCmp,                    // Enable comparator output
   input wire logic modeSelectPin,                // High selects serial mode
   input wire logic phaseThreeSenseNeg,           // Third phase sense tied high
   input wire logic phaseFourSenseNeg,            // Fourth phase sense tied high
   input wire logic fixedVoltageSelect,           // Fixed boot voltage select
   input wire logic serialVidData,                // Serial VID data pin
   input wire logic serialVidClock,               // Serial VID clock pin
   input wire logic [5:0] parallelVid,            // Parallel VID code
   input wire logic coreFbAboveRef,               // Core feedback above reference
   input wire logic nbFbAboveRef,                 // Northbridge feedback above reference
   input wire logic outputsInLimits,              // Both outputs inside UV/OV limits
   output logic [7:0] coreRef,                    // Core reference DAC code
   output logic [7:0] nbRef,                      // Northbridge reference DAC code
   output logic coreDriveEn,                      // Core switches allowed to run
   output logic nbDriveEn,                        // Northbridge switches allowed to run
   output logic power_good,                       // Power-good indication
   output logic serialMode,                       // Latched mode, 1 is serial
   output rss_phase_e phaseMode,                  // Detected core phase count
   output logic softStartBusy                     // Soft-start in progress
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   rss_pins_s pinRaw;
   rss_pins_s pinMeta;
   rss_pins_s pins;

   // Parallel VID is synced bit by bit, so it must be steady at start
   assign pinRaw = '{
      mainBias: mainBiasPorOk,
      coreDriverBias: coreDriverBias,
      auxDriverBias: auxDriverBias,
      enable: enableCmp,
      modeSelectPin: modeSelectPin,
      phaseThreeSenseNeg: phaseThreeSenseNeg,
      phaseFourSenseNeg: phaseFourSenseNeg,
      fixedVoltageSelect: fixedVoltageSelect,
      serialVidData: serialVidData,
      serialVidClock: serialVidClock,
      coreFbHigh: coreFbAboveRef,
      nbFbHigh: nbFbAboveRef,
      inLimits: outputsInLimits,
      parallelVid: parallelVid
   };

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pinMeta <= '0;
         pins <= '0;
      end
      else
      begin
         pinMeta <= pinRaw;
         pins <= pinMeta;
      end
   end

   // ----------------------------------------------------------------
   // Qualification
   // ----------------------------------------------------------------
   rss_state_e state;
   rss_state_e next_state;
   logic enPrev;
   logic [RSS_DLY_W-1:0] dlyCnt;
   logic [RSS_STEP_W-1:0] stepCnt;
   logic [RSS_REF_W-1:0] refCode [RSS_NOUT];
   logic [RSS_REF_W-1:0] target [RSS_NOUT];
   logic [RSS_NOUT-1:0] driveEn;
   logic [RSS_NOUT-1:0] fbHigh;
   logic [RSS_NOUT-1:0] outActive;
   logic [RSS_NOUT-1:0] atTarget;

   wire biasOk = pins.mainBias & pins.coreDriverBias & pins.auxDriverBias;
   wire enQual = pins.mainBias & pins.enable;
   wire runOk = biasOk & enQual;
   wire enRise = enQual & ~enPrev;

   // Start also needs both driver biases, the same as runOk
   wire startOk = runOk;

   // ----------------------------------------------------------------
   // Target decoding
   // ----------------------------------------------------------------
   wire [1:0] bootSel = {pins.serialVidData, pins.serialVidClock};
   wire [RSS_REF_W-1:0] sviCore = pins.fixedVoltageSelect ? RSS_FIXED_CORE
                                                         : RSS_BOOT_CORE[bootSel];
   wire [RSS_REF_W-1:0] sviNb = pins.fixedVoltageSelect ? RSS_FIXED_NB
                                                       : RSS_BOOT_NB[bootSel];
   wire [RSS_REF_W-1:0] pviCore = RSS_PVID_TOP_CODE - {pins.parallelVid, RSS_PVID_PAD};
   wire [RSS_REF_W-1:0] coreGoal = serialMode ? sviCore : pviCore;
   wire [RSS_REF_W-1:0] nbGoal = serialMode ? sviNb : RSS_REF_ZERO;

   wire rss_phase_e phaseSeen = (pins.phaseThreeSenseNeg && pins.phaseFourSenseNeg)
                                ? PH_TWO
                                : (pins.phaseFourSenseNeg ? PH_THREE : PH_FOUR);

   wire delayDone = (dlyCnt == RSS_DLY_W'(START_DELAY_CYC - 1));
   wire stepTick = (stepCnt == RSS_STEP_W'(RSS_STEP_CYC - 1));
   wire rampDone = &atTarget;

   assign fbHigh = {pins.nbFbHigh, pins.coreFbHigh};
   assign outActive = {serialMode, 1'b1};

   // ----------------------------------------------------------------
   // Sequencer state machine
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         ST_OFF:
            if (runOk)
               next_state = ST_INIT;
         ST_INIT:
            if (startOk)
               next_state = ST_DELAY;
         ST_DELAY:
            if (delayDone)
               next_state = ST_RAMP;
         ST_RAMP:
            if (rampDone)
               next_state = ST_DONE;
         ST_DONE:
            next_state = ST_DONE;
         default:
            next_state = ST_OFF;
      endcase
      if (!runOk)
         next_state = ST_OFF;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         state <= ST_OFF;
      else
         state <= next_state;
   end

   // ----------------------------------------------------------------
   // Mode latch and phase detect
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         enPrev <= 1'b0;
         serialMode <= 1'b0;
      end
      else
      begin
         enPrev <= enQual;
         if (enRise)
            serialMode <= pins.modeSelectPin;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         phaseMode <= PH_FOUR;
      else if (state == ST_INIT && startOk)
         phaseMode <= phaseSeen;
   end

   // ----------------------------------------------------------------
   // Delay and step counters
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n || state != ST_DELAY)
         dlyCnt <= '0;
      else
         dlyCnt <= dlyCnt + RSS_DLY_W'(1);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n || state != ST_RAMP || stepTick)
         stepCnt <= '0;
      else
         stepCnt <= stepCnt + RSS_STEP_W'(1);
   end

   // ----------------------------------------------------------------
   // Target hold
   // ----------------------------------------------------------------
   // Serial pins turn into a live bus after boot, so a restart after a
   // driver bias dip reuses the targets taken at the first start
   logic targetHeld;

   wire captureNow = (state == ST_INIT) && startOk && !targetHeld;

   always_ff @(posedge clk)
   begin
      if (!rst_n || !enQual)
         targetHeld <= 1'b0;
      else if (captureNow)
         targetHeld <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Per-output target, reference ramp and drive gating
   // ----------------------------------------------------------------
   for (genvar i = 0; i < RSS_NOUT; i++)
   begin : g_out
      wire [RSS_REF_W-1:0] goal = (i == RSS_CORE) ? coreGoal : nbGoal;

      assign atTarget[i] = (refCode[i] == target[i]);

      always_ff @(posedge clk)
      begin
         // Only reset, enable low or main bias loss clears a captured target
         if (!rst_n || !enQual)
            target[i] <= RSS_REF_ZERO;
         else if (captureNow)
            target[i] <= goal;
      end

      always_ff @(posedge clk)
      begin
         if (!rst_n || state == ST_OFF || state == ST_INIT)
            refCode[i] <= RSS_REF_ZERO;
         else if (state == ST_RAMP && stepTick && !atTarget[i])
            refCode[i] <= refCode[i] + RSS_REF_W'(1);
      end

      always_ff @(posedge clk)
      begin
         if (!rst_n || !outActive[i] || state == ST_OFF || state == ST_INIT
             || state == ST_DELAY)
            driveEn[i] <= 1'b0;
         else if (state == ST_DONE)
            driveEn[i] <= 1'b1;
         else if (!fbHigh[i])
            driveEn[i] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign coreRef = refCode[RSS_CORE];
   assign nbRef = refCode[RSS_NB];
   assign coreDriveEn = driveEn[RSS_CORE];
   assign nbDriveEn = driveEn[RSS_NB];

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         power_good <= 1'b0;
         softStartBusy <= 1'b0;
      end
      else
      begin
         power_good <= (state == ST_DONE) && runOk && pins.inLimits;
         // Follows next_state so busy moves with the state register
         softStartBusy <= (next_state == ST_DELAY) || (next_state == ST_RAMP);
      end
   end

endmodule : rss_regulator_startup_sequencer

// file: tb/rss_checker.sv
// Port checker for the start-up sequencer
`timescale 1ns/1ps
module rss_checker
   import rss_pkg::*;
#(
   parameter int START_DELAY_CYC = 20
)
(
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic mainBiasPorOk, // Main bias
   input wire logic coreDriverBias, // Core bias
   input wire logic enableCmp, // Enable
   input wire logic [7:0] coreRef, // Core ref
   input wire logic [7:0] nbRef, // NB ref
   input wire logic coreDriveEn, // Core drive
   input wire logic nbDriveEn, // NB drive
   input wire logic power_good, // Power good
   input wire logic serialMode, // Mode
   input wire logic softStartBusy // Busy
);
   // ----
   // Assertions
   // ----
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic [15:0] busyCnt;

   // Cycles spent busy, saturating
   always_ff @(posedge clk)
   begin
      if (!rst_n || !softStartBusy)
         busyCnt <= 16'h0000;
      else if (busyCnt != 16'hFFFF)
         busyCnt <= busyCnt + 16'h0001;
   end

   pg_in_start_a: assert property (softStartBusy |-> !power_good)
      else $error("power good during soft-start");
   main_bias_a: assert property (!mainBiasPorOk [*5] |-> !softStartBusy && !power_good)
      else $error("running without main bias");
   driver_bias_a: assert property (!coreDriverBias [*5] |-> !softStartBusy && !coreDriveEn)
      else $error("running without driver bias");
   enable_off_a: assert property (!enableCmp [*5] |-> coreRef == 8'h00 && !power_good)
      else $error("active while disabled");
   ref_step_a: assert property (softStartBusy && $past(softStartBusy)
      && coreRef != $past(coreRef) |-> coreRef == $past(coreRef) + 8'h01)
      else $error("reference jumped");
   step_space_a: assert property (softStartBusy && $changed(coreRef)
      |=> ($stable(coreRef) || !softStartBusy) [*8])
      else $error("steps too close");
   start_delay_a: assert property ($rose(softStartBusy)
      |-> (coreRef == 8'h00 && !coreDriveEn && !nbDriveEn) [*8])
      else $error("ramp or drive during delay");
   pg_after_ramp_a: assert property ($rose(power_good)
      |-> coreDriveEn && !softStartBusy && !$past(softStartBusy))
      else $error("power good too early");
   mode_hold_a: assert property (softStartBusy && $past(softStartBusy)
      |-> $stable(serialMode))
      else $error("mode changed in soft-start");
   nb_parked_a: assert property (!serialMode |-> nbRef == 8'h00 && !nbDriveEn)
      else $error("northbridge active in parallel mode");
   delay_len_a: assert property (softStartBusy && coreRef != 8'h00
      |-> busyCnt >= 16'(START_DELAY_CYC + RSS_STEP_CYC))
      else $error("ramp before start delay");

   cover property ($rose(power_good) && serialMode);
   cover property ($rose(coreDriveEn) && softStartBusy);
   cover property ($rose(softStartBusy) && !serialMode);
endmodule : rss_checker

// file: tb/rss_power_stage_model.sv
// Power stage model: output levels and feedback compare
`timescale 1ns/1ps
module rss_power_stage_model
   import rss_pkg::*;
(
   input wire logic [7:0] coreRef, // Core ref
   input wire logic [7:0] nbRef, // NB ref
   input wire logic coreDriveEn, // Core drive
   input wire logic nbDriveEn, // NB drive
   input wire logic [7:0] corePre, // Core pre-charge
   input wire logic [7:0] nbPre, // NB pre-charge
   output logic coreFbAboveRef, // Core fb high
   output logic nbFbAboveRef, // NB fb high
   output logic outputsInLimits // Outputs good
);
   logic [7:0] coreLevel;
   logic [7:0] nbLevel;
   // Idle output keeps its charge, driven one tracks the reference
   assign coreLevel = coreDriveEn ? coreRef : corePre;
   assign nbLevel = nbDriveEn ? nbRef : nbPre;
   assign coreFbAboveRef = coreLevel >= coreRef;
   assign nbFbAboveRef = nbLevel >= nbRef;
   assign outputsInLimits = coreDriveEn && (nbDriveEn || nbRef == 8'h00);
endmodule : rss_power_stage_model

// file: tb/rss_regulator_startup_sequencer_test.sv
// Self-checking bench for the start-up sequencer
`timescale 1ns/1ps
module rss_regulator_startup_sequencer_test
   import rss_pkg::*;
;
   localparam int DLY = 20;
   logic clk;
   logic rst_n;
   rss_pins_s pins;
   logic [7:0] corePre;
   logic [7:0] nbPre;
   logic coreFb;
   logic nbFb;
   logic inLim;
   logic [7:0] coreRef;
   logic [7:0] nbRef;
   logic coreDriveEn;
   logic nbDriveEn;
   logic power_good;
   logic serialMode;
   rss_phase_e phaseMode;
   logic softStartBusy;
   int num_errors;
   int comparisons;

   rss_regulator_startup_sequencer #(.START_DELAY_CYC(DLY)) rss_regulator_startup_sequencer_inst (
      .clk, .rst_n, .mainBiasPorOk(pins.mainBias), .coreDriverBias(pins.coreDriverBias),
      .auxDriverBias(pins.auxDriverBias), .enableCmp(pins.enable),
      .modeSelectPin(pins.modeSelectPin), .phaseThreeSenseNeg(pins.phaseThreeSenseNeg),
      .phaseFourSenseNeg(pins.phaseFourSenseNeg), .fixedVoltageSelect(pins.fixedVoltageSelect),
      .serialVidData(pins.serialVidData), .serialVidClock(pins.serialVidClock),
      .parallelVid(pins.parallelVid), .coreFbAboveRef(coreFb), .nbFbAboveRef(nbFb),
      .outputsInLimits(inLim), .coreRef, .nbRef, .coreDriveEn, .nbDriveEn, .power_good,
      .serialMode, .phaseMode, .softStartBusy);
   rss_power_stage_model rss_power_stage_model_inst (.coreRef, .nbRef, .coreDriveEn,
      .nbDriveEn, .corePre, .nbPre, .coreFbAboveRef(coreFb), .nbFbAboveRef(nbFb),
      .outputsInLimits(inLim));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ----
   // Helpers
   // ----
   task automatic chk1(input logic got, input logic exp, input string msg);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask : chk1
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL %0t %s", $time, msg);
      end
   endtask : chk8
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : step
   task automatic close_out();
      $display("compares %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task automatic wait_on(ref logic s, input int lim);
      int i = 0;
      while (s !== 1'b1 && i < lim)
      begin
         step(1);
         i++;
      end
      if (s !== 1'b1)
      begin
         num_errors++;
         $display("FAIL %0t wait ran out", $time);
         close_out();
      end
   endtask : wait_on
   task automatic go(input logic sel);
      pins.modeSelectPin = sel;
      pins.enable = 1'b1;
      wait_on(softStartBusy, 20);
      chk1(serialMode, sel, "mode");
   endtask : go
   task automatic stop();
      pins.enable = 1'b0;
      step(6);
      chk8(coreRef, 8'h00, "ref after disable");
      chk1(power_good, 1'b0, "power good after disable");
   endtask : stop

   // ----
   // Scenarios
   // ----
   task automatic t_bias();
      pins.coreDriverBias = 1'b1;
      pins.enable = 1'b1;
      pins.modeSelectPin = 1'b1;
      step(30);
      chk1(softStartBusy, 1'b0, "start without main bias");
      chk1(serialMode, 1'b0, "mode without main bias");
      pins.mainBias = 1'b1;
      step(30);
      chk1(softStartBusy, 1'b0, "start without aux bias");
      pins.enable = 1'b0;
      pins.auxDriverBias = 1'b1;
      step(10);
      $display("bias test done");
   endtask : t_bias
   task automatic t_phase();
      rss_phase_e exp[4] = '{PH_FOUR, PH_THREE, PH_FOUR, PH_TWO};
      for (int k = 0; k < 4; k++)
      begin
         {pins.phaseThreeSenseNeg, pins.phaseFourSenseNeg} = k[1:0];
         go(1'b0);
         chk8({6'h00, phaseMode}, {6'h00, exp[k]}, "phase count");
         stop();
      end
      $display("phase test done");
   endtask : t_phase
   task automatic t_parallel();
      corePre = 8'h04;
      pins.parallelVid = 6'h3C;
      go(1'b0);
      pins.parallelVid = 6'h00;
      wait_on(coreDriveEn, 2000);
      chk8(coreRef, corePre + 8'h01, "drive start level");
      wait_on(power_good, 2000);
      chk8(coreRef, RSS_PVID_TOP_CODE - {6'h3C, RSS_PVID_PAD}, "core target");
      chk8(nbRef, 8'h00, "nb ref");
      chk1(nbDriveEn, 1'b0, "nb drive");
      stop();
      $display("parallel test done");
   endtask : t_parallel
   task automatic t_abort();
      corePre = 8'h00;
      for (int k = 0; k < 2; k++)
      begin
         go(1'b0);
         step(DLY + 200);
         chk1(coreDriveEn, 1'b1, "drive before bias loss");
         if (k == 0)
            pins.mainBias = 1'b0;
         else
            pins.coreDriverBias = 1'b0;
         step(6);
         chk8(coreRef, 8'h00, "ref after bias loss");
         chk1(coreDriveEn, 1'b0, "drive after bias loss");
         pins.mainBias = 1'b1;
         pins.coreDriverBias = 1'b1;
         stop();
      end
      $display("abort test done");
   endtask : t_abort
   task automatic t_serial(input logic fix, input logic [7:0] pre, input logic [7:0] expC,
                           input logic [7:0] expN);
      corePre = 8'h00;
      nbPre = pre;
      pins.fixedVoltageSelect = fix;
      {pins.serialVidData, pins.serialVidClock} = 2'b11;
      go(1'b1);
      pins.modeSelectPin = 1'b0;
      if (pre < expN)
      begin
         wait_on(nbDriveEn, 20000);
         chk8(nbRef, pre + 8'h01, "nb drive start");
      end
      else
      begin
         step(3000);
         chk1(nbDriveEn, 1'b0, "nb drive in ramp");
      end
      wait_on(power_good, 20000);
      chk8(coreRef, expC, "core serial target");
      chk8(nbRef, expN, "nb serial target");
      chk1(nbDriveEn, 1'b1, "nb drive at end");
      chk1(serialMode, 1'b1, "mode held");
      stop();
      $display("serial test done");
   endtask : t_serial

   initial
   begin
      rst_n = 1'b0;
      pins = '0;
      corePre = 8'h00;
      nbPre = 8'h00;
      num_errors = 0;
      comparisons = 0;
      step(2);
      rst_n = 1'b1;
      t_bias();
      t_phase();
      t_parallel();
      t_abort();
      t_serial(1'b0, 8'hFF, RSS_BOOT_CORE[3], RSS_BOOT_NB[3]);
      t_serial(1'b1, 8'h10, RSS_FIXED_CORE, RSS_FIXED_NB);
      close_out();
   end
endmodule : rss_regulator_startup_sequencer_test

bind rss_regulator_startup_sequencer rss_checker #(.START_DELAY_CYC(START_DELAY_CYC))
   rss_checker_inst (.clk, .rst_n, .mainBiasPorOk, .coreDriverBias, .enableCmp, .coreRef,
   .nbRef, .coreDriveEn, .nbDriveEn, .power_good, .serialMode, .softStartBusy);
